// ---- design/sac_conv_ctrl.sv ----
// conversion control for a 10-bit successive-approximation converter
`timescale 1ns/1ns
`include "sac_map.svh"
module sac_conv_ctrl #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // trigger sources, one bit per select code
  input  wire logic [7:0]           trig_src,
  // analog core
  output sac_pkg::sac_analog_t      analog_cfg,
  output logic                      sample_start,
  input  wire logic [RES_W-1:0]     core_result,
  // interrupt request
  output logic                      irq
);
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  sac_pkg::sac_mux_t   mux_reg;
  sac_pkg::sac_mux_t   mux_live;
  logic [7:0]          csa;
  logic [2:0]          csb;
  logic [7:0]          res_low;
  logic [7:0]          res_high;
  logic                locked;
  logic                first_conv;
  logic [6:0]          presc;
  logic [4:0]          cyc;
  logic                trig_prev;
  logic                sc_pending;

  wire en     = csa[`SAC_CSA_EN];
  wire ate    = csa[`SAC_CSA_ATE];
  wire wr_csa = reg_wr && reg_addr == `SAC_OFF_CSA;
  wire wr_mux = reg_wr && reg_addr == `SAC_OFF_MUX;
  wire rd_low = reg_rd && reg_addr == `SAC_OFF_LOW;
  wire rd_hi  = reg_rd && reg_addr == `SAC_OFF_HIGH;
  // prescaler tap chosen by the prescaler select field
  wire [2:0] ps_sel  = csa[2:0];
  wire [2:0] ps_idx  = (ps_sel == 3'h0) ? 3'h0 : 3'(ps_sel - 3'h1);
  wire       adc_tick = en && (presc & 7'((8'h02 << ps_idx) - 8'h01)) ==
                        7'((8'h02 << ps_idx) - 8'h01);
  wire       converting = state == sac_pkg::SAC_CONV;
  wire       done = converting && adc_tick && cyc == 5'h01;
  wire       trig_lvl  = trig_src[csb];
  wire       trig_free = csb == `SAC_TRIG_FREE;
  // edges seen while busy are dropped by sampling only when idle
  wire       trig_edge = en && ate && !trig_free && trig_lvl && !trig_prev &&
                         state == sac_pkg::SAC_IDLE;
  wire       sw_start = wr_csa && reg_wdata[`SAC_CSA_SC] && reg_wdata[`SAC_CSA_EN];
  wire       free_restart = done && ate && trig_free;
  // software start waits for the next prescaled tick
  wire       start_now = trig_edge || free_restart ||
                         (state == sac_pkg::SAC_WAIT && adc_tick);
  // a restart at completion is never the first conversion
  wire [4:0] conv_len = (first_conv && !done) ? `SAC_FIRST_CYC : `SAC_NORMAL_CYC;
  wire [RES_W-1:0] code = core_result;

  function automatic logic [15:0] align(input logic [RES_W-1:0] v, input logic left);
    align = left ? {v, 6'h00} : {6'h00, v};
  endfunction
  wire [15:0] aligned = align(code, mux_live.left_adj);

  always_comb begin
    next_state = state;
    unique case (state)
      sac_pkg::SAC_IDLE: begin
        if (trig_edge) next_state = sac_pkg::SAC_CONV;
        else if (sc_pending || sw_start) next_state = sac_pkg::SAC_WAIT;
      end
      sac_pkg::SAC_WAIT: begin
        if (!en) next_state = sac_pkg::SAC_IDLE;
        else if (adc_tick) next_state = sac_pkg::SAC_CONV;
      end
      sac_pkg::SAC_CONV: begin
        if (!en) next_state = sac_pkg::SAC_IDLE;
        else if (done) next_state = free_restart ? sac_pkg::SAC_CONV : sac_pkg::SAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) state <= sac_pkg::SAC_IDLE;
    else     state <= next_state;
  end

  always_ff @(posedge clk) begin
    if (rst || !en || trig_edge) presc <= 7'h00;
    else                         presc <= 7'(presc + 7'h01);
  end

  always_ff @(posedge clk) begin
    if (rst || !en) begin
      cyc        <= 5'h00;
      first_conv <= 1'b1;
    end else begin
      if (start_now)                    cyc <= conv_len;
      else if (converting && adc_tick)  cyc <= 5'(cyc - 5'h01);
      if (done)                         first_conv <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) trig_prev <= 1'b0;
    else     trig_prev <= trig_lvl;
  end

  // software start even under auto trigger
  always_ff @(posedge clk) begin
    if (rst || !en || state != sac_pkg::SAC_IDLE) sc_pending <= 1'b0;
    else if (sw_start && trig_edge)               sc_pending <= 1'b0;
    else                                          sc_pending <= sw_start;
  end

  // control register; flag set wins over clear
  wire sc_busy = state != sac_pkg::SAC_IDLE || sc_pending;
  always_ff @(posedge clk) begin
    if (rst) begin
      csa <= 8'h00;
    end else begin
      if (wr_csa) begin
        csa[`SAC_CSA_EN]  <= reg_wdata[`SAC_CSA_EN];
        csa[`SAC_CSA_ATE] <= reg_wdata[`SAC_CSA_ATE];
        csa[`SAC_CSA_IE]  <= reg_wdata[`SAC_CSA_IE];
        csa[2:0]          <= reg_wdata[2:0];
      end
      if (done) csa[`SAC_CSA_IF] <= 1'b1;
      else if (wr_csa && reg_wdata[`SAC_CSA_IF]) csa[`SAC_CSA_IF] <= 1'b0;
      csa[`SAC_CSA_SC] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)                             csb <= 3'h0;
    else if (reg_wr && reg_addr == `SAC_OFF_CSB) csb <= reg_wdata[2:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mux_reg  <= '0;
      mux_live <= '0;
    end else begin
      if (wr_mux) mux_reg <= {reg_wdata[7:6], reg_wdata[`SAC_MUX_LAR], reg_wdata[4:0]};
      if (!converting || done) mux_live <= mux_reg;
    end
  end

  // result lock between low and high reads
  always_ff @(posedge clk) begin
    if (rst) begin
      locked   <= 1'b0;
      res_low  <= 8'h00;
      res_high <= 8'h00;
    end else begin
      if (rd_low)     locked <= 1'b1;
      else if (rd_hi) locked <= 1'b0;
      if (done && !locked) begin
        res_low  <= aligned[7:0];
        res_high <= aligned[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      analog_cfg   <= '0;
      sample_start <= 1'b0;
    end else begin
      analog_cfg.enable      <= en;
      analog_cfg.ref_sel     <= en ? mux_live.ref_sel : 2'h0;
      analog_cfg.channel     <= en ? mux_live.channel : 5'h00;
      analog_cfg.gain_bypass <= !en || mux_live.channel < 5'h08 || mux_live.channel > 5'h1d;
      sample_start           <= start_now;
    end
  end

  wire [7:0] csa_view = {csa[7], sc_busy, csa[5:0]};
  wire [7:0] rd_mux_v;
  assign rd_mux_v = {mux_reg.ref_sel, mux_reg.left_adj, mux_reg.channel};
  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      unique case (reg_addr)
        `SAC_OFF_LOW:  reg_rdata <= res_low;
        `SAC_OFF_HIGH: reg_rdata <= res_high;
        `SAC_OFF_CSA:  reg_rdata <= csa_view;
        `SAC_OFF_MUX:  reg_rdata <= rd_mux_v;
        `SAC_OFF_CSB:  reg_rdata <= {5'h00, csb};
        default:       reg_rdata <= 8'h00;
      endcase
    end else reg_rdata <= 8'h00;
  end

  assign irq = csa[`SAC_CSA_IF] && csa[`SAC_CSA_IE];

  // rely on software ordering; nothing enforced here

  property p_flag_on_done;
    @(posedge clk) disable iff (rst) done |=> csa[`SAC_CSA_IF];
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set");
  property p_lock_hold;
    @(posedge clk) disable iff (rst) (locked && !rd_hi) |=> $stable(res_low);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result changed");
  property p_unlock;
    @(posedge clk) disable iff (rst) rd_hi && !rd_low |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock not released");
  property p_busy;
    @(posedge clk) disable iff (rst) converting |-> sc_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("start bit low while busy");
  property p_irq;
    @(posedge clk) disable iff (rst) (done && csa[`SAC_CSA_IE] && !wr_csa) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_presc_off;
    @(posedge clk) disable iff (rst) !en |=> presc == 7'h00;
  endproperty
  a_presc_off: assert property (p_presc_off) else $error("prescaler ran");
  property p_len;
    @(posedge clk) disable iff (rst) (start_now && !first_conv) |=> cyc == `SAC_NORMAL_CYC;
  endproperty
  a_len: assert property (p_len) else $error("wrong length");
  property p_mux_hold;
    @(posedge clk) disable iff (rst) (converting && $past(converting) && !$past(done))
      |-> $stable(mux_live);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("selection changed");
endmodule // sac_conv_ctrl

// ---- design/sac_map.svh ----
// register offsets, field positions, timing counts and the free-running trigger code for the converter control
// Notes on behaviour
// - result is a 10-bit code, zero is ground, all ones is reference less one lsb
// - reference select picks analog supply, internal 2.56V, or external reference
// - channel select picks input channel and gain, including ground and bandgap
// - two differential pairs offer 1x, 10x, 200x gain; single-ended bypasses gain
// - reference and channel take effect only when enabled; disabled draws no power
// - result right-aligned by default, left-aligned when left-adjust bit is set
// - after low byte read, completions do not update result; result discarded
// - reading high byte releases the lock
// - completion flag sets on every completion, even a discarded one
// - start bit begins single conversion, stays one, cleared on completion
// - channel written during conversion applies only after it finishes
// - with auto trigger, rising edge of selected source resets prescaler and starts
// - trigger high at completion does not restart; edges during conversion ignored
// - free-running restarts at every completion whether or not the flag is cleared
// - start bit still starts a single conversion while auto trigger is enabled
// - start bit reads one during every conversion however started
// - normal conversion lasts 13 converter clocks, first after enable lasts 25
// - at completion write result, set flag, clear start bit together
// - prescaler runs while enabled and is held in reset while disabled
// - software start begins on the next prescaled converter clock edge
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_OFF_LOW      3'h0
`define SAC_OFF_HIGH     3'h1
`define SAC_OFF_CSA      3'h2
`define SAC_OFF_MUX      3'h3
`define SAC_OFF_CSB      3'h4
`define SAC_CSA_EN       7
`define SAC_CSA_SC       6
`define SAC_CSA_ATE      5
`define SAC_CSA_IF       4
`define SAC_CSA_IE       3
`define SAC_MUX_LAR      5
`define SAC_NORMAL_CYC   5'h0d
`define SAC_FIRST_CYC    5'h19
`define SAC_TRIG_FREE    3'h0
`endif

// ---- design/sac_pkg.sv ----
// types for the converter control
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT = 2'b01,
    SAC_CONV = 2'b11
  } sac_state_t;
  typedef struct packed {
    logic [1:0] ref_sel;
    logic       left_adj;
    logic [4:0] channel;
  } sac_mux_t;
  typedef struct packed {
    logic       enable;
    logic [1:0] ref_sel;
    logic [4:0] channel;
    logic       gain_bypass;
  } sac_analog_t;
endpackage

// ---- sim/sac_analog_model.sv ----
// behavioural model of the analog inputs and the trigger sources
`timescale 1ns/1ns
module sac_analog_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench controls
  input  wire logic [9:0] analog_val,
  input  wire logic [7:0] trig_lvl,
  // converter side
  input  wire logic       sample_start,
  output logic      [9:0] core_result,
  output logic      [7:0] trig_src
);
  // code held from sample
  // held until the next sample, so a late read cannot see a newer input
  always_ff @(posedge clk) begin
    if (rst) begin
      core_result <= 10'h000;
    end else if (sample_start) begin
      core_result <= analog_val;
    end
  end
  always_ff @(posedge clk) begin
    trig_src <= rst ? 8'h00 : trig_lvl;
  end
endmodule // sac_analog_model

// ---- sim/tb.sv ----
// self-checking bench for the converter control
`timescale 1ns/1ns
`include "sac_map.svh"
module tb;
  logic                 clk;
  logic                 rst;
  logic [2:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_rdata;
  logic [7:0]           trig_src;
  logic [7:0]           trig_lvl;
  logic [9:0]           analog_val;
  logic [9:0]           core_result;
  logic                 sample_start;
  logic                 irq;
  sac_pkg::sac_analog_t analog_cfg;
  int                   num_errors;
  int                   compares;
  int                   starts = 0;
  int                   s0;
  int                   cyc;
  logic [7:0]           rd_val;
  logic [9:0]           v;
  logic [9:0]           v2;
  logic [7:0]           m;
  int                   chans [6] = '{0, 7, 8, 29, 30, 31};

  always #5 clk = ~clk;
  always @(posedge clk) if (sample_start === 1'b1) starts <= starts + 1;

  sac_conv_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_src(trig_src),
    .analog_cfg(analog_cfg), .sample_start(sample_start), .core_result(core_result), .irq(irq));
  sac_analog_model model (.clk(clk), .rst(rst), .analog_val(analog_val), .trig_lvl(trig_lvl),
    .sample_start(sample_start), .core_result(core_result), .trig_src(trig_src));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // polls the start bit; each poll costs two cycles
  task automatic wait_done;
    cyc = 0;
    rd(`SAC_OFF_CSA);
    while (rd_val[`SAC_CSA_SC] === 1'b1 && cyc < 400) begin
      rd(`SAC_OFF_CSA);
      cyc += 2;
    end
  endtask
  task automatic run_conv(input logic [7:0] csa, input int lo, input int hi);
    wr(`SAC_OFF_CSA, csa);
    wait_done();
    chk(16'(cyc >= lo && cyc <= hi), 16'h1);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    results();
  end

  initial begin
    clk = 0; rst = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    trig_lvl = 0; analog_val = 0;
    void'($urandom(53908));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk({8'h0, rd_val}, 16'h0);
    end
    $display("test reset done");
    wr(`SAC_OFF_MUX, 8'h45);
    repeat (3) @(posedge clk);
    chk({15'h0, analog_cfg.enable}, 16'h0);
    wr(`SAC_OFF_CSA, 8'h80);
    foreach (chans[i]) begin
      m = {2'($urandom), 1'b0, 5'(chans[i])};
      wr(`SAC_OFF_MUX, m);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, analog_cfg}, {7'h0, 1'b1, m[7:6], m[4:0], !(m[4:0] inside {[8:29]})});
    end
    $display("test selection done");
    wr(`SAC_OFF_MUX, 8'h00);
    v = 10'($urandom);
    analog_val <= v;
    run_conv(8'hc8, 44, 62);
    rd(`SAC_OFF_CSA);
    chk({8'h0, rd_val}, 16'h0098);
    chk({15'h0, irq}, 16'h1);
    rd(`SAC_OFF_LOW);
    chk({8'h0, rd_val}, {8'h0, v[7:0]});
    rd(`SAC_OFF_HIGH);
    chk({8'h0, rd_val}, {14'h0, v[9:8]});
    wr(`SAC_OFF_CSA, 8'h98);
    rd(`SAC_OFF_CSA);
    chk({7'h0, irq, rd_val}, 16'h0088);
    wr(`SAC_OFF_MUX, 8'h20);
    v = 10'($urandom);
    analog_val <= v;
    run_conv(8'hc8, 20, 36);
    rd(`SAC_OFF_HIGH);
    chk({8'h0, rd_val}, {8'h0, v[9:2]});
    rd(`SAC_OFF_LOW);
    chk({8'h0, rd_val}, {8'h0, v[1:0], 6'h0});
    // high read releases the lock left by the low read
    rd(`SAC_OFF_HIGH);
    $display("test single done");
    wr(`SAC_OFF_MUX, 8'h00);
    v = 10'h3ff;
    v2 = 10'($urandom);
    analog_val <= v;
    run_conv(8'hd8, 20, 36);
    rd(`SAC_OFF_LOW);
    chk({8'h0, rd_val}, {8'h0, v[7:0]});
    analog_val <= v2;
    run_conv(8'hd8, 20, 36);
    rd(`SAC_OFF_CSA);
    chk({15'h0, rd_val[`SAC_CSA_IF]}, 16'h1);
    rd(`SAC_OFF_HIGH);
    chk({8'h0, rd_val}, {14'h0, v[9:8]});
    run_conv(8'hd8, 20, 36);
    rd(`SAC_OFF_LOW);
    rd(`SAC_OFF_HIGH);
    chk({8'h0, rd_val}, {14'h0, v2[9:8]});
    $display("test lock done");
    wr(`SAC_OFF_CSB, 8'h03);
    wr(`SAC_OFF_CSA, 8'hb8);
    s0 = starts;
    trig_lvl <= 8'h08;
    repeat (6) @(posedge clk);
    trig_lvl <= 8'h00;
    rd(`SAC_OFF_CSA);
    chk({15'h0, rd_val[`SAC_CSA_SC]}, 16'h1);
    trig_lvl <= 8'h08;
    wait_done();
    repeat (40) @(posedge clk);
    chk(16'(starts - s0), 16'h1);
    wr(`SAC_OFF_CSA, 8'hf8);
    wait_done();
    chk(16'(starts - s0), 16'h2);
    $display("test trigger done");
    trig_lvl <= 8'h00;
    wr(`SAC_OFF_CSB, 8'h00);
    s0 = starts;
    wr(`SAC_OFF_CSA, 8'he8);
    repeat (150) @(posedge clk);
    chk(16'(starts - s0 >= 4), 16'h1);
    wr(`SAC_OFF_CSA, 8'h80);
    wait_done();
    $display("test free running done");
    wr(`SAC_OFF_MUX, 8'h01);
    wr(`SAC_OFF_CSA, 8'hc0);
    for (int i = 0; i < 20 && sample_start !== 1'b1; i++) @(negedge clk);
    wr(`SAC_OFF_MUX, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk({11'h0, analog_cfg.channel}, 16'h1);
    wait_done();
    repeat (3) @(posedge clk);
    #1 chk({11'h0, analog_cfg.channel}, 16'h2);
    wr(`SAC_OFF_CSA, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({7'h0, analog_cfg}, 16'h0001);
    $display("test channel and disable done");
    results();
  end
endmodule // tb
